// ---- verification/adcci_analog_model.sv ----
// analog input pinned at one of the references, with its comparator
`timescale 1ns/1ps
module adcci_analog_model (
  // input level and sampling switch
  input  wire logic i_over,
  input  wire logic i_sample,
  // comparator
  output logic      o_comp_above
);
  logic held = 1'b0;
  // the level is held while the switch is open, like the sampling capacitor
  always @(i_sample or i_over)
    if (i_sample)
      held = i_over;
  // at high reference every trial lies below, at low reference none does
  assign o_comp_above = held;
endmodule

// ---- verification/adcci_top_properties.sv ----
// port assertions for the converter control block
`timescale 1ns/1ps
module adcci_top_properties (
  // clock, reset and register port
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [3:0]  i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // converter outputs
  input wire logic [4:0]  o_channel,
  input wire logic        o_sample,
  input wire logic        o_low_power,
  input wire logic [15:0] o_pin_disable,
  input wire logic [9:0]  o_dac_code,
  input wire logic        o_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_tcc_zero_bits: assert property (
    $past(i_rd && i_addr == 4'h1) |-> o_rdata[3:0] == 4'h0)
    else $error("reserved control bits read nonzero");
  a_active_flag: assert property (
    $past(i_rd && i_addr == 4'h1) |-> o_rdata[7] == $past(o_active))
    else $error("active flag differs from active output");
  a_chan_read: assert property (
    $past(i_rd && i_addr == 4'h2) |-> o_rdata[4:0] == $past(o_channel))
    else $error("channel field differs from channel output");
  a_chan_cause: assert property (
    $changed(o_channel) |-> $past(i_wr && i_addr == 4'h2)
      || $past(i_wr && i_addr == 4'h2, 2))
    else $error("channel changed without a write");
  a_lp_cause: assert property (
    $changed(o_low_power) |-> $past(i_wr && i_addr == 4'h0)
      || $past(i_wr && i_addr == 4'h0, 2))
    else $error("low power changed without a write");
  a_pin_cause: assert property (
    $changed(o_pin_disable) |-> $past(i_wr && i_addr inside {4'h7, 4'h8}, 1)
      || $past(i_wr && i_addr inside {4'h7, 4'h8}, 2))
    else $error("pin disable changed without a write");
  a_sample_active: assert property (o_sample |-> o_active)
    else $error("sampling outside a conversion");
  a_unmapped_zero: assert property (
    $past(i_rd && i_addr > 4'h8) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_code_idle: assert property (
    !o_active |-> o_dac_code == 10'h000)
    else $error("trial code left on the array while idle");
  c_conv_done: cover property ($fell(o_active));
  c_sampling: cover property ($rose(o_sample));
  c_pins: cover property (o_pin_disable == 16'h0002);
endmodule

// ---- verification/adcci_top_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcci_top_tb;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} adcci_row_t;
  logic        i_clk, i_nrst, i_wr, i_rd, i_alt_clk, i_hw_trigger, over;
  logic        comp, o_sample, o_low_power, o_active, o_irq;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [4:0]  o_channel;
  logic [9:0]  o_dac_code;
  logic [15:0] o_pin_disable;
  int          err_count, n_tests, nc, n0, n1;
  logic [7:0]  cs [3] = '{8'h09, 8'h0a, 8'h0b};
  // init order: config, then trigger/compare, then compare value, pin disable and an unmapped offset
  adcci_row_t  rows [8] = '{
    '{4'h0, 8'h98, 8'h98},
    '{4'h1, 8'h7c, 8'h70},
    '{4'h1, 8'h00, 8'h00},
    '{4'h5, 8'h03, 8'h03},
    '{4'h6, 8'h55, 8'h55},
    '{4'h7, 8'h02, 8'h02},
    '{4'h8, 8'h00, 8'h00},
    '{4'hf, 8'haa, 8'h00}};
  adcci_top adcci_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_alt_clk(i_alt_clk), .i_hw_trigger(i_hw_trigger), .i_comp_above(comp),
    .o_channel(o_channel), .o_sample(o_sample), .o_dac_code(o_dac_code),
    .o_low_power(o_low_power), .o_pin_disable(o_pin_disable),
    .o_active(o_active), .o_irq(o_irq));
  adcci_analog_model adcci_analog_model_inst (.i_over(over),
    .i_sample(o_sample), .o_comp_above(comp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk({8'h00, o_rdata}, {8'h00, e});
    @(posedge i_clk);
  endtask
  // bounded wait; the count is left in nc for timing checks
  task automatic wt(ref logic s, input logic v);
    int n;
    for (n = 0; n < 4000 && s !== v; n++)
      @(posedge i_clk) #1;
    nc = n;
    if (n == 4000)
    begin
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test();
    end
    @(posedge i_clk);
  endtask
  task automatic conv(input logic [7:0] cc);
    wr(4'h2, cc);
    #1 chk(o_active, 1'b1);
    wt(o_active, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial
  begin
    i_alt_clk = 1'b0;
    forever #24 i_alt_clk = ~i_alt_clk;
  end
  initial
  begin
    {i_nrst, i_wr, i_rd, i_hw_trigger, i_addr, i_wdata} = '0;
    over = 1'b1;
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    rdc(4'h0, 8'h00);
    rdc(4'h2, 8'h1f);
    chk(o_channel, 5'h1f);
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d);
      rdc(rows[k].a, rows[k].e);
    end
    chk(o_pin_disable, 16'h0002);
    chk(o_low_power, 1'b1);
    conv(8'h41);
    n1 = nc;
    rdc(4'h2, 8'hc1);
    chk(o_irq, 1'b1);
    rdc(4'h3, 8'h03);
    rdc(4'h4, 8'hff);
    chk(o_irq, 1'b0);
    wr(4'h0, 8'h08);
    conv(8'h01);
    n0 = nc;
    chk(16'(n1 - n0), 16'd20);
    wr(4'h0, 8'h28);
    conv(8'h01);
    chk(nc > n0, 1'b1);
    foreach (cs[i])
    begin
      wr(4'h0, cs[i]);
      conv(8'h01);
      rdc(4'h3, 8'h03);
      rdc(4'h4, 8'hff);
    end
    // compare threshold 0x355 from the rows; the code is full scale, so the result is 0xaa
    wr(4'h0, 8'h08);
    wr(4'h1, 8'h20);
    conv(8'h01);
    rdc(4'h2, 8'h01);
    wr(4'h1, 8'h30);
    conv(8'h01);
    rdc(4'h3, 8'h00);
    rdc(4'h4, 8'haa);
    wr(4'h1, 8'h40);
    wr(4'h2, 8'h01);
    #1 chk(o_active, 1'b0);
    @(posedge i_clk);
    i_hw_trigger <= 1'b1;
    repeat (8) @(posedge i_clk);
    #1 chk(o_active, 1'b1);
    @(posedge i_clk);
    i_hw_trigger <= 1'b0;
    wt(o_active, 1'b0);
    // continuous 8-bit: a locked result survives later conversions
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h61);
    wt(o_irq, 1'b1);
    rdc(4'h3, 8'h00);
    over <= 1'b0;
    repeat (300) @(posedge i_clk);
    rdc(4'h4, 8'hff);
    @(posedge i_clk);
    wt(o_irq, 1'b1);
    rdc(4'h3, 8'h00);
    rdc(4'h4, 8'h00);
    #1 chk(o_active, 1'b1);
    @(posedge i_clk);
    wr(4'h2, 8'h1f);
    #1 chk(o_active, 1'b0);
    @(posedge i_clk);
    conv(8'h01);
    chk(o_irq, 1'b0);
    rdc(4'h2, 8'h81);
    rdc(4'h4, 8'h00);
    end_of_test();
  end
endmodule
bind adcci_top adcci_top_properties adcci_top_properties_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_channel(o_channel),
  .o_sample(o_sample), .o_low_power(o_low_power),
  .o_pin_disable(o_pin_disable), .o_dac_code(o_dac_code),
  .o_active(o_active));

// ---- verilog/adcci_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef ADCCI_DEFS_SVH
`define ADCCI_DEFS_SVH

// register offsets on the 4-bit register port
`define ADCCI_OFS_CONFIG      4'h0
`define ADCCI_OFS_TRIG_CMP    4'h1
`define ADCCI_OFS_CHAN_CTRL   4'h2
`define ADCCI_OFS_RESULT_HIGH 4'h3
`define ADCCI_OFS_RESULT_LOW  4'h4
`define ADCCI_OFS_CMP_HIGH    4'h5
`define ADCCI_OFS_CMP_LOW     4'h6
`define ADCCI_OFS_PIN_LOW     4'h7
`define ADCCI_OFS_PIN_HIGH    4'h8

// conversion_config fields
`define ADCCI_CFG_LOW_POWER   7
`define ADCCI_CFG_DIV_HI      6
`define ADCCI_CFG_DIV_LO      5
`define ADCCI_CFG_LONG_SAMPLE 4
`define ADCCI_CFG_MODE_HI     3
`define ADCCI_CFG_MODE_LO     2
`define ADCCI_CFG_CLK_HI      1
`define ADCCI_CFG_CLK_LO      0
`define ADCCI_MODE_10BIT      2'h2
`define ADCCI_CLK_BUS         2'h0
`define ADCCI_CLK_BUS_HALF    2'h1
`define ADCCI_CLK_ALT         2'h2

// trigger_compare_control and channel_conversion_control fields
`define ADCCI_TCC_ACTIVE      7
`define ADCCI_TCC_TRIGGER     6
`define ADCCI_TCC_CMP_EN      5
`define ADCCI_TCC_CMP_GT      4
`define ADCCI_CCC_COMPLETE    7
`define ADCCI_CCC_IRQ_EN      6
`define ADCCI_CCC_CONT        5

// reset values
`define ADCCI_RST_CONFIG      8'h00
`define ADCCI_RST_CHANNEL     5'h1f
`define ADCCI_CHAN_OFF        5'h1f

// timing counts in conversion-clock cycles and bus cycles
`define ADCCI_SAMPLE_SHORT    5'h03
`define ADCCI_SAMPLE_LONG     5'h17
`define ADCCI_SETTLE          2'h3
`define ADCCI_ASYNC_DIV       4'h3

`endif

// ---- verilog/adcci_pkg.sv ----
// types shared by the converter control block
package adcci_pkg;

  typedef enum logic [1:0] {
    ADCCI_IDLE    = 2'b00,
    ADCCI_SAMPLE  = 2'b01,
    ADCCI_CONVERT = 2'b10
  } adcci_state_t;

  typedef struct packed {
    logic [7:0]   cfg;
    logic         trig_sel;
    logic         cmp_en;
    logic         cmp_gt;
    logic         complete;
    logic         irq_en;
    logic         cont;
    logic [4:0]   chan;
    logic [9:0]   result;
    logic [9:0]   cmp_val;
    logic [7:0]   pin_lo;
    logic [7:0]   pin_hi;
    logic         lock;
    adcci_state_t state;
    logic         active;
    logic         sample;
    logic [4:0]   samp_cnt;
    logic [3:0]   bit_idx;
    logic [9:0]   trial;
    logic [1:0]   settle;
    logic [2:0]   src_cnt;
    logic [3:0]   async_cnt;
    logic         alt_s1;
    logic         alt_s2;
    logic         alt_prev;
    logic         trg_s1;
    logic         trg_s2;
    logic         trg_prev;
    logic         cmp_s1;
    logic         cmp_s2;
    logic [7:0]   rdata;
    logic         irq;
  } adcci_state_reg_t;

endpackage

// ---- verilog/adcci_top.sv ----
// digital control and register file of the successive-approximation converter
`timescale 1ns/1ps
`include "adcci_defs.svh"

module adcci_top (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // pins and analog core
  input  wire logic       i_alt_clk,
  input  wire logic       i_hw_trigger,
  input  wire logic       i_comp_above,
  output logic      [4:0] o_channel,
  output logic            o_sample,
  output logic      [9:0] o_dac_code,
  output logic            o_low_power,
  output logic     [15:0] o_pin_disable,
  // status
  output logic            o_active,
  output logic            o_irq
);

  adcci_pkg::adcci_state_reg_t s;
  adcci_pkg::adcci_state_reg_t n;

  logic       src_pulse;
  logic [2:0] div_mask;
  logic       ck_en;
  logic       is_10bit;
  logic       trg_rise;
  logic       start;
  logic       abort;
  logic       keep_bit;
  logic [9:0] final_code;
  logic       cmp_hit;
  logic [9:0] cmp_diff;

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a state flop

  assign o_rdata       = s.rdata;
  assign o_channel     = s.chan;
  assign o_sample      = s.sample;
  assign o_dac_code    = s.trial;
  assign o_low_power   = s.cfg[`ADCCI_CFG_LOW_POWER];
  assign o_pin_disable = {s.pin_hi, s.pin_lo};
  assign o_active      = s.active;
  assign o_irq         = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    n          = s;
    src_pulse  = 1'b0;
    div_mask   = 3'h0;
    ck_en      = 1'b0;
    is_10bit   = 1'b0;
    trg_rise   = 1'b0;
    start      = 1'b0;
    abort      = 1'b0;
    keep_bit   = 1'b0;
    final_code = 10'h000;
    cmp_hit    = 1'b0;
    cmp_diff   = 10'h000;

    // pin synchronisers; the first stage is never looked at
    n.alt_s1   = i_alt_clk;
    n.alt_s2   = s.alt_s1;
    n.alt_prev = s.alt_s2;
    n.trg_s1   = i_hw_trigger;
    n.trg_s2   = s.trg_s1;
    n.trg_prev = s.trg_s2;
    n.cmp_s1   = i_comp_above;
    n.cmp_s2   = s.cmp_s1;
    n.rdata    = 8'h00;

    // input clock source as a bus-cycle enable
    n.async_cnt = (s.async_cnt == `ADCCI_ASYNC_DIV) ? 4'h0
                                                   : s.async_cnt + 4'h1;
    unique case (s.cfg[`ADCCI_CFG_CLK_HI:`ADCCI_CFG_CLK_LO])
      `ADCCI_CLK_BUS:      src_pulse = 1'b1;
      `ADCCI_CLK_BUS_HALF: src_pulse = s.async_cnt[0];
      `ADCCI_CLK_ALT:      src_pulse = s.alt_s2 & ~s.alt_prev;
      default:             src_pulse = (s.async_cnt == `ADCCI_ASYNC_DIV);
    endcase

    // conversion clock divider: 1, 2, 4 or 8
    unique case (s.cfg[`ADCCI_CFG_DIV_HI:`ADCCI_CFG_DIV_LO])
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
    if (src_pulse)
    begin
      n.src_cnt = ((s.src_cnt & div_mask) == div_mask) ? 3'h0
                                                       : s.src_cnt + 3'h1;
      ck_en     = ((s.src_cnt & div_mask) == div_mask);
    end

    is_10bit = (s.cfg[`ADCCI_CFG_MODE_HI:`ADCCI_CFG_MODE_LO]
                == `ADCCI_MODE_10BIT);
    trg_rise = s.trg_s2 & ~s.trg_prev;

    // register writes
    if (i_wr)
    begin
      unique case (i_addr)
        `ADCCI_OFS_CONFIG: n.cfg = i_wdata;
        `ADCCI_OFS_TRIG_CMP:
        begin
          // bits 7 and 3:0 are not stored
          n.trig_sel = i_wdata[`ADCCI_TCC_TRIGGER];
          n.cmp_en   = i_wdata[`ADCCI_TCC_CMP_EN];
          n.cmp_gt   = i_wdata[`ADCCI_TCC_CMP_GT];
        end
        `ADCCI_OFS_CHAN_CTRL:
        begin
          n.irq_en   = i_wdata[`ADCCI_CCC_IRQ_EN];
          n.cont     = i_wdata[`ADCCI_CCC_CONT];
          n.chan     = i_wdata[4:0];
          n.complete = 1'b0;
          n.lock     = 1'b0;
          abort      = 1'b1;
          start      = ~s.trig_sel && (i_wdata[4:0] != `ADCCI_CHAN_OFF);
        end
        `ADCCI_OFS_CMP_HIGH: n.cmp_val[9:8] = i_wdata[1:0];
        `ADCCI_OFS_CMP_LOW:  n.cmp_val[7:0] = i_wdata;
        `ADCCI_OFS_PIN_LOW:  n.pin_lo       = i_wdata;
        `ADCCI_OFS_PIN_HIGH: n.pin_hi       = i_wdata;
        default:             n.pin_hi       = s.pin_hi;
      endcase
    end

    // register reads; data appear in the following cycle only
    if (i_rd)
    begin
      unique case (i_addr)
        `ADCCI_OFS_CONFIG: n.rdata = s.cfg;
        `ADCCI_OFS_TRIG_CMP:
          n.rdata = {s.active, s.trig_sel, s.cmp_en, s.cmp_gt,
                     4'h0};
        `ADCCI_OFS_CHAN_CTRL:
          n.rdata = {s.complete, s.irq_en, s.cont, s.chan};
        `ADCCI_OFS_RESULT_HIGH:
        begin
          n.rdata = {6'h00, is_10bit ? s.result[9:8] : 2'h0};
          n.lock  = 1'b1;
        end
        `ADCCI_OFS_RESULT_LOW:
        begin
          n.rdata    = s.result[7:0];
          n.lock     = 1'b0;
          n.complete = 1'b0;
        end
        `ADCCI_OFS_CMP_HIGH: n.rdata = {6'h00, s.cmp_val[9:8]};
        `ADCCI_OFS_CMP_LOW:  n.rdata = s.cmp_val[7:0];
        `ADCCI_OFS_PIN_LOW:  n.rdata = s.pin_lo;
        `ADCCI_OFS_PIN_HIGH: n.rdata = s.pin_hi;
        default:             n.rdata = 8'h00;
      endcase
    end

    // hardware trigger only while idle and enabled
    if (s.trig_sel && trg_rise && (s.state == adcci_pkg::ADCCI_IDLE)
        && (s.chan != `ADCCI_CHAN_OFF) && !abort)
      start = 1'b1;

    // conversion sequencer
    if (abort)
    begin
      n.state  = adcci_pkg::ADCCI_IDLE;
      n.active = 1'b0;
      n.sample = 1'b0;
      n.trial  = 10'h000; // a dropped conversion leaves no code on the array
    end
    else
    begin
      unique case (s.state)
        adcci_pkg::ADCCI_IDLE:
        begin
          n.active = 1'b0;
        end
        adcci_pkg::ADCCI_SAMPLE:
        begin
          if (ck_en)
          begin
            if (s.samp_cnt == 5'h00)
            begin
              n.state   = adcci_pkg::ADCCI_CONVERT;
              n.sample  = 1'b0;
              n.bit_idx = is_10bit ? 4'h9 : 4'h7;
              n.trial   = is_10bit ? 10'h200 : 10'h080;
              n.settle  = `ADCCI_SETTLE;
            end
            else
              n.samp_cnt = s.samp_cnt - 5'h01;
          end
        end
        adcci_pkg::ADCCI_CONVERT:
        begin
          if (s.settle != 2'h0)
            n.settle = s.settle - 2'h1;
          else if (ck_en)
          begin
            // comparator stuck high or low saturates the code
            keep_bit   = s.cmp_s2;
            final_code = keep_bit ? s.trial
                                  : s.trial & ~(10'h001 << s.bit_idx);
            if (s.bit_idx == 4'h0)
            begin
              cmp_diff = final_code - s.cmp_val;
              cmp_hit  = s.cmp_gt ? (final_code >= s.cmp_val)
                                  : (final_code < s.cmp_val);
              // a locked result drops the finished code
              if (!n.lock && (!s.cmp_en || cmp_hit))
              begin
                n.result   = s.cmp_en ? cmp_diff : final_code;
                n.complete = 1'b1;
              end
              n.trial = 10'h000;
              if (s.cont)
              begin
                n.state    = adcci_pkg::ADCCI_SAMPLE;
                n.sample   = 1'b1;
                n.samp_cnt = s.cfg[`ADCCI_CFG_LONG_SAMPLE]
                             ? `ADCCI_SAMPLE_LONG : `ADCCI_SAMPLE_SHORT;
              end
              else
              begin
                n.state  = adcci_pkg::ADCCI_IDLE;
                n.active = 1'b0;
              end
            end
            else
            begin
              n.bit_idx = s.bit_idx - 4'h1;
              n.trial   = final_code | (10'h001 << (s.bit_idx - 4'h1));
              n.settle  = `ADCCI_SETTLE;
            end
          end
        end
        default:
        begin
          n.state  = adcci_pkg::ADCCI_IDLE;
          n.active = 1'b0;
        end
      endcase
    end

    // new conversion; the window may end up to one conversion cycle early by alignment
    if (start)
    begin
      n.state    = adcci_pkg::ADCCI_SAMPLE;
      n.active   = 1'b1;
      n.sample   = 1'b1;
      n.trial    = 10'h000;
      n.samp_cnt = s.cfg[`ADCCI_CFG_LONG_SAMPLE]
                   ? `ADCCI_SAMPLE_LONG : `ADCCI_SAMPLE_SHORT;
    end

    n.irq = n.complete & n.irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      s          <= '0;
      s.cfg      <= `ADCCI_RST_CONFIG;
      s.chan     <= `ADCCI_RST_CHANNEL;
      s.state    <= adcci_pkg::ADCCI_IDLE;
    end
    else
      s <= n;
  end

endmodule
